// ===== core/leb_map.vh
`ifndef LEB_MAP_VH
`define LEB_MAP_VH
// Bus clock divider: 40 MHz / 8 = 5 MHz bus clock
`define LEB_CLK_DIV 8'h04
// Reset hold after power good, in bus clock periods
`define LEB_RST_HOLD 16'h0040
// Address limit for the low-meg strobes (bit 20 and up zero)
`define LEB_LOW_MEG_BIT 20
// Default wait states per command phase
`define LEB_WAIT_STATES 4'h4
// Command codes
`define LEB_CMD_MEM_RD 3'h0
`define LEB_CMD_MEM_WR 3'h1
`define LEB_CMD_IO_RD 3'h2
`define LEB_CMD_IO_WR 3'h3
`define LEB_CMD_INTA 3'h4
`define LEB_CMD_REFRESH 3'h5
`define LEB_CMD_DMA_RD 3'h6
`define LEB_CMD_DMA_WR 3'h7
// FIFO shape
`define LEB_FIFO_DEPTH 16
`define LEB_FIFO_AW 4
`endif

// ===== core/leb_fifo.v
`timescale 1ns/1ps
// ****************************************
// Read data FIFO
// ****************************************
module leb_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // Fill side
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
    reg [AW:0] wr_q; // Write pointer with wrap bit
    reg [AW:0] rd_q; // Read pointer with wrap bit
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rd_q[AW-1:0]];
    // Pointer and storage update
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (i_in_valid && !full) begin
                mem[wr_q[AW-1:0]] <= i_in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (i_out_ready && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // leb_fifo

// ===== core/leb_host.v
// How it works
// - Sixteen data lines, read capture, write drive
// - Not-ready card stretches command until ready
// - Address enable high during DMA and refresh
// - Low address floats during hold acknowledge
// - Upper slot address driven with low lines
// - Latched upper address inputs in master cycle
// - Command strobes inputs during master cycle
// - Slot reset held during power up
// - Eleven interrupt request inputs accepted
// - DMA requests answered by matching acknowledge
// - Acknowledge pins sampled as straps
// - Zero-wait input ends CPU command at once
// - Low-meg strobes only below one megabyte
// - Refresh indicator marks refresh cycles
// - Device outputs the bus clock
// - Address latch enable marks valid address
// - Terminal count pulses at DMA end
`timescale 1ns/1ps
`include "leb_map.vh"
module leb_host #(
    parameter RST_HOLD = `LEB_RST_HOLD,
    parameter WAIT_STATES = `LEB_WAIT_STATES
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_power_good,
    // Request side from CPU/DMA logic
    input wire i_req_valid,
    output wire o_req_ready,
    input wire [2:0] i_req_cmd,
    input wire [23:0] i_req_addr,
    input wire [15:0] i_req_wdata,
    input wire i_req_wide,
    input wire i_req_last,
    input wire [2:0] i_req_dma_ch,
    // Read data stream
    output wire o_rd_valid,
    input wire i_rd_ready,
    output wire [15:0] o_rd_data,
    // Status
    output reg o_busy,
    output reg o_channel_error,
    output reg [15:0] o_irq_level,
    output reg [7:0] o_dma_pending,
    output reg [7:0] o_strap_q,
    output reg o_cycle_wide,
    // Hold / bus master
    input wire i_hold_ack,
    input wire i_master_cycle,
    // Slot pins
    output reg o_bus_clock_out,
    output reg o_address_latch_enable,
    output reg o_address_enable_out,
    output reg o_slot_reset_out,
    output reg o_refresh_n,
    output reg o_transfer_count_done,
    input wire [15:0] i_slot_data_bus,
    output reg [15:0] o_slot_data_bus,
    output reg o_slot_data_oe,
    input wire [19:0] i_slot_address_bus,
    output reg [19:0] o_slot_address_bus,
    output wire [19:0] o_slot_address_oe,
    input wire [23:17] i_latched_upper_address,
    output reg [23:17] o_latched_upper_address,
    output wire o_latched_upper_oe,
    input wire i_byte_high_enable_n,
    output reg o_byte_high_enable_n,
    output wire o_byte_high_enable_oe,
    input wire [3:0] i_strobes_n,
    output wire [3:0] o_strobes_n,
    output wire o_strobes_oe,
    output wire o_low_meg_read_strobe_n,
    output wire o_low_meg_write_strobe_n,
    input wire i_channel_ready,
    input wire i_zero_wait_in_n,
    input wire i_channel_error_in_n,
    input wire i_wide_memory_select_n,
    input wire i_wide_io_select_n,
    input wire [15:0] i_irq,
    input wire [7:0] i_dma_request_in,
    input wire [7:0] i_dma_acknowledge_n,
    output reg [7:0] o_dma_acknowledge_n,
    output wire [7:0] o_dma_acknowledge_oe
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CMD = 3'h2;
    localparam ST_END = 3'h3;
    localparam ST_PUSH = 3'h4;
    // Valid interrupt lines and DMA channels
    localparam [15:0] IRQ_MASK = 16'hDEF8;
    localparam [7:0] DMA_MASK = 8'hEF;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam SW = 2 + 4 + 16 + 8 + 8 + 1 + 7 + 20 + 1;
    wire [SW-1:0] raw = {i_channel_ready, i_zero_wait_in_n, i_channel_error_in_n,
        i_wide_memory_select_n, i_wide_io_select_n, i_strobes_n[3], i_irq,
        i_dma_request_in, i_dma_acknowledge_n, i_byte_high_enable_n,
        i_latched_upper_address, i_slot_address_bus, i_power_good};
    reg [SW-1:0] s1_q; // First stage, read only by second
    reg [SW-1:0] s2_q; // Second stage
    reg [15:0] sd1_q; // Data first stage
    reg [15:0] sd2_q; // Data second stage
    // Two-flop sampling of every slot input pin except strobes 2 to 0
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1_q <= {SW{1'b0}};
            s2_q <= {SW{1'b0}};
            sd1_q <= 16'h0000;
            sd2_q <= 16'h0000;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            sd1_q <= i_slot_data_bus;
            sd2_q <= sd1_q;
        end
    end
    wire rdy_s = s2_q[SW-1];
    wire zws_n_s = s2_q[SW-2];
    wire err_n_s = s2_q[SW-3];
    wire mcs_n_s = s2_q[SW-4];
    wire ics_n_s = s2_q[SW-5];
    wire [15:0] irq_s = s2_q[SW-7 -: 16];
    wire [7:0] drq_s = s2_q[SW-23 -: 8];
    wire [7:0] dma_acknowledge_n_s = s2_q[SW-31 -: 8];
    wire pgood_s = s2_q[0];

    // ****************************************
    // Bus clock divider
    // ****************************************
    reg [7:0] div_q; // Divider count
    reg tick_q; // One-cycle enable on bus clock rising edge
    // Generates the slot clock and a rising-edge enable
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_q <= 8'h00;
            o_bus_clock_out <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (div_q == `LEB_CLK_DIV - 8'h01) begin
                div_q <= 8'h00;
                o_bus_clock_out <= !o_bus_clock_out;
                tick_q <= !o_bus_clock_out;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // ****************************************
    // Slot reset and strap capture
    // ****************************************
    reg [15:0] rst_cnt_q; // Hold counter after power good
    // Slot reset stays high until power good plus hold time
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            rst_cnt_q <= 16'h0000;
            o_slot_reset_out <= 1'b1;
            o_strap_q <= 8'h00;
        end else if (!pgood_s) begin
            rst_cnt_q <= 16'h0000;
            o_slot_reset_out <= 1'b1;
        end else if (o_slot_reset_out) begin
            if (rst_cnt_q == RST_HOLD[15:0]) begin
                o_slot_reset_out <= 1'b0;
                o_strap_q <= dma_acknowledge_n_s;
            end else if (tick_q) begin
                rst_cnt_q <= rst_cnt_q + 16'h0001;
            end
        end
    end
    assign o_dma_acknowledge_oe = {8{!o_slot_reset_out}} & DMA_MASK;

    // ****************************************
    // Status capture
    // ****************************************
    // Interrupt, DMA request and error levels
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq_level <= 16'h0000;
            o_dma_pending <= 8'h00;
            o_channel_error <= 1'b0;
        end else begin
            o_irq_level <= irq_s & IRQ_MASK;
            o_dma_pending <= drq_s & DMA_MASK;
            o_channel_error <= !err_n_s;
        end
    end

    // ****************************************
    // Cycle engine
    // ****************************************
    reg [2:0] st_q; // Engine state
    reg [2:0] cmd_q; // Current command
    reg [23:0] addr_q; // Current address
    reg [3:0] wait_q; // Wait state count
    reg last_q; // DMA last transfer
    reg cmd_on_q; // Command strobe active
    reg [15:0] rdata_q; // Captured read data
    wire fifo_ready;
    wire is_read = (cmd_q == `LEB_CMD_MEM_RD) || (cmd_q == `LEB_CMD_IO_RD) ||
        (cmd_q == `LEB_CMD_INTA) || (cmd_q == `LEB_CMD_DMA_RD);
    wire is_dma = (cmd_q == `LEB_CMD_DMA_RD) || (cmd_q == `LEB_CMD_DMA_WR);
    wire is_cpu = !is_dma && (cmd_q != `LEB_CMD_REFRESH);
    wire owner = !i_hold_ack && !i_master_cycle;
    assign o_req_ready = (st_q == ST_IDLE) && owner && !o_slot_reset_out;
    // Main sequencer; address and command phases advance on bus clock ticks
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            cmd_q <= `LEB_CMD_MEM_RD;
            addr_q <= 24'h000000;
            wait_q <= 4'h0;
            last_q <= 1'b0;
            cmd_on_q <= 1'b0;
            rdata_q <= 16'h0000;
            o_busy <= 1'b0;
            o_address_latch_enable <= 1'b0;
            o_address_enable_out <= 1'b0;
            o_refresh_n <= 1'b1;
            o_transfer_count_done <= 1'b0;
            o_dma_acknowledge_n <= 8'hFF;
            o_slot_data_bus <= 16'h0000;
            o_slot_data_oe <= 1'b0;
            o_byte_high_enable_n <= 1'b1;
            o_cycle_wide <= 1'b0;
        end else begin
            o_transfer_count_done <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (i_req_valid && o_req_ready) begin
                        cmd_q <= i_req_cmd;
                        addr_q <= i_req_addr;
                        last_q <= i_req_last;
                        o_busy <= 1'b1;
                        o_byte_high_enable_n <= !i_req_wide;
                        o_slot_data_bus <= i_req_wdata;
                        st_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (tick_q) begin
                        o_address_latch_enable <= 1'b1;
                        // DMA and refresh own the bus
                        o_address_enable_out <= !is_cpu;
                        o_refresh_n <= (cmd_q != `LEB_CMD_REFRESH);
                        if (is_dma) begin
                            o_dma_acknowledge_n <= ~(8'h01 << i_req_dma_ch) | ~DMA_MASK;
                        end
                        o_slot_data_oe <= (cmd_q == `LEB_CMD_MEM_WR) ||
                            (cmd_q == `LEB_CMD_IO_WR) || (cmd_q == `LEB_CMD_DMA_WR);
                        wait_q <= WAIT_STATES[3:0];
                        st_q <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (tick_q) begin
                        o_address_latch_enable <= 1'b0;
                        cmd_on_q <= 1'b1;
                        o_cycle_wide <= !mcs_n_s || !ics_n_s;
                        if (cmd_on_q && is_cpu && !zws_n_s) begin
                            st_q <= ST_END;
                        end else if (cmd_on_q && wait_q == 4'h0 && rdy_s) begin
                            st_q <= ST_END;
                        end else if (wait_q != 4'h0) begin
                            wait_q <= wait_q - 4'h1;
                        end
                    end
                end
                ST_END: begin
                    rdata_q <= sd2_q;
                    cmd_on_q <= 1'b0;
                    o_slot_data_oe <= 1'b0;
                    o_address_enable_out <= 1'b0;
                    o_refresh_n <= 1'b1;
                    o_dma_acknowledge_n <= 8'hFF;
                    o_transfer_count_done <= is_dma && last_q;
                    st_q <= (is_read && cmd_q != `LEB_CMD_REFRESH) ? ST_PUSH : ST_IDLE;
                    o_busy <= is_read;
                end
                ST_PUSH: begin
                    if (fifo_ready) begin
                        o_busy <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Address and strobe pins
    // ****************************************
    // Address register follows the cycle
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_slot_address_bus <= 20'h00000;
            o_latched_upper_address <= 7'h00;
        end else begin
            o_slot_address_bus <= addr_q[19:0];
            o_latched_upper_address <= addr_q[23:17];
        end
    end
    wire drive = owner && !o_slot_reset_out;
    assign o_slot_address_oe = {{3{drive}}, {17{drive}}};
    assign o_latched_upper_oe = drive;
    assign o_byte_high_enable_oe = drive;
    assign o_strobes_oe = drive;
    // Exactly one strobe from the decoded command
    wire mem_rd = (cmd_q == `LEB_CMD_MEM_RD) || (cmd_q == `LEB_CMD_REFRESH) ||
        (cmd_q == `LEB_CMD_DMA_WR);
    wire mem_wr = (cmd_q == `LEB_CMD_MEM_WR) || (cmd_q == `LEB_CMD_DMA_RD);
    wire io_rd = (cmd_q == `LEB_CMD_IO_RD) || (cmd_q == `LEB_CMD_INTA);
    wire io_wr = (cmd_q == `LEB_CMD_IO_WR);
    wire act = cmd_on_q && (st_q == ST_CMD);
    // Order: memory read, memory write, io read, io write
    assign o_strobes_n = ~({mem_rd, mem_wr, io_rd, io_wr} & {4{act}});
    wire low_meg = (addr_q[23:`LEB_LOW_MEG_BIT] == 4'h0);
    assign o_low_meg_read_strobe_n = !(act && mem_rd && low_meg);
    assign o_low_meg_write_strobe_n = !(act && mem_wr && low_meg);

    // ****************************************
    // Read data FIFO
    // ****************************************
    leb_fifo #(
        .WIDTH(16),
        .DEPTH(`LEB_FIFO_DEPTH),
        .AW(`LEB_FIFO_AW)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_in_valid(st_q == ST_PUSH),
        .o_in_ready(fifo_ready),
        .i_in_data(rdata_q),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );
endmodule // leb_host

// ===== verif/leb_host_monitor.sv
`timescale 1ns/1ps
// ******
// Slot pin checker
// ******
module leb_host_monitor (
    // Clock and controls
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_power_good,
    input wire i_hold_ack,
    input wire i_master_cycle,
    input wire i_channel_ready,
    input wire i_zero_wait_in_n,
    // Slot side outputs
    input wire o_busy,
    input wire o_address_enable_out,
    input wire o_slot_reset_out,
    input wire o_refresh_n,
    input wire o_transfer_count_done,
    input wire o_slot_data_oe,
    input wire [19:0] o_slot_address_oe,
    input wire [23:17] o_latched_upper_address,
    input wire o_latched_upper_oe,
    input wire o_byte_high_enable_oe,
    input wire [3:0] o_strobes_n,
    input wire o_strobes_oe,
    input wire o_low_meg_read_strobe_n,
    input wire o_low_meg_write_strobe_n,
    input wire [7:0] o_dma_acknowledge_n,
    input wire [7:0] o_dma_acknowledge_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire act = o_strobes_oe && o_strobes_n != 4'hF; // A command strobe is driven low
    wire lm = !o_low_meg_read_strobe_n || !o_low_meg_write_strobe_n; // Low-meg strobe on
    one_strobe_a: assert property (o_strobes_oe |-> $countones(~o_strobes_n) <= 1)
        else $error("two command strobes low");
    master_release_a: assert property (i_master_cycle [*3] |-> !o_strobes_oe
        && !o_latched_upper_oe && !o_byte_high_enable_oe) else $error("pins kept in master cycle");
    hold_float_a: assert property (i_hold_ack [*3] |-> o_slot_address_oe[16:0] == 17'h00000)
        else $error("low address driven in hold");
    upper_addr_a: assert property (o_slot_address_oe[19:17] == {3{o_slot_address_oe[16]}})
        else $error("upper address apart from low");
    reset_hold_a: assert property (!i_power_good [*6] |-> o_slot_reset_out)
        else $error("slot reset off without power");
    low_meg_a: assert property (lm |-> o_latched_upper_address[23:20] == 4'h0)
        else $error("low meg strobe above one meg");
    stretch_a: assert property ((act && !i_channel_ready && i_zero_wait_in_n && !i_hold_ack
        && !i_master_cycle) [*4] |=> act) else $error("command ended while not ready");
    addr_enable_a: assert property ((!o_refresh_n
        || (o_dma_acknowledge_oe & ~o_dma_acknowledge_n) != 8'h00) |-> o_address_enable_out)
        else $error("address enable low in dma or refresh");
    tc_pulse_a: assert property (o_transfer_count_done |=> !o_transfer_count_done)
        else $error("terminal count too long");
    idle_release_a: assert property (!o_busy |-> !o_slot_data_oe && !act)
        else $error("pins held while idle");
    // Main scenarios reached
    cover property (act && !o_refresh_n);
    cover property ($fell(o_dma_acknowledge_n[5]));
    cover property (o_strobes_oe ##1 !o_strobes_oe);
endmodule // leb_host_monitor

bind leb_host leb_host_monitor leb_host_monitor_i (.*);

// ===== verif/leb_card.sv
`timescale 1ns/1ps
// ******
// Card on the slot
// ******
module leb_card (
    // Clock and strobe pins
    input wire i_ref_clk,
    input wire [3:0] i_strobes_n,
    // Knobs from the bench
    input wire [15:0] i_rd_word,
    input wire [7:0] i_wait,
    // Driven back to the host
    output logic [15:0] o_card_data,
    output logic o_card_ready,
    output logic o_card_wide_n
);
    logic [7:0] cnt_q = 8'h00; // Clocks into the command
    logic [15:0] last_q = 16'h0000; // Last word on the lines
    wire rd = !i_strobes_n[3] || !i_strobes_n[1]; // Memory or I/O read seen
    // Count the command length, saturating
    always @(posedge i_ref_clk) begin
        cnt_q <= (&i_strobes_n) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
        last_q <= o_card_data;
    end
    assign o_card_ready = &i_strobes_n || cnt_q >= i_wait;
    assign o_card_wide_n = &i_strobes_n;
    // Read word while read, else a pattern that moves every clock
    assign o_card_data = rd ? i_rd_word : ~last_q;
endmodule // leb_card

// ===== verif/leb_host_test.sv
`timescale 1ns/1ps
`include "leb_map.vh"
// ******
// Host bench
// ******
module leb_host_test;
    logic i_ref_clk = 0, i_rst = 1, i_power_good = 0, i_req_valid = 0, i_req_wide = 1;
    logic i_req_last = 0, i_rd_ready = 0, i_hold_ack = 0, i_master_cycle = 0, tc_seen = 0;
    logic i_zero_wait_in_n = 1, i_channel_error_in_n = 1;
    logic [2:0] i_req_cmd = 3'h0, i_req_dma_ch = 3'h0;
    logic [23:0] i_req_addr = 24'h000000;
    logic [15:0] i_req_wdata = 16'h0000, i_irq = 16'h0000, rd_word = 16'h0000;
    logic [7:0] i_dma_request_in = 8'h00, card_wait = 8'h00;
    wire [15:0] i_slot_data_bus, card_data, o_rd_data, o_irq_level, o_slot_data_bus;
    wire [19:0] i_slot_address_bus, o_slot_address_bus, o_slot_address_oe;
    wire [23:17] i_latched_upper_address, o_latched_upper_address;
    wire [7:0] i_dma_acknowledge_n, o_dma_pending, o_strap_q, o_dma_acknowledge_n;
    wire [7:0] o_dma_acknowledge_oe;
    wire [3:0] i_strobes_n, o_strobes_n;
    wire i_byte_high_enable_n, i_channel_ready, i_wide_memory_select_n, i_wide_io_select_n;
    wire o_req_ready, o_rd_valid, o_busy, o_channel_error, o_cycle_wide, o_bus_clock_out;
    wire o_address_latch_enable, o_address_enable_out, o_slot_reset_out, o_refresh_n;
    wire o_transfer_count_done, o_slot_data_oe, o_latched_upper_oe, o_byte_high_enable_n;
    wire o_byte_high_enable_oe, o_strobes_oe, o_low_meg_read_strobe_n, o_low_meg_write_strobe_n;
    int miscompares = 0, compares = 0, wid;
    localparam logic [7:0] STRAP = 8'hA5; // Pulled levels on the acknowledge pins
    localparam int WAIT_CLK = `LEB_WAIT_STATES * 2 * `LEB_CLK_DIV; // Plain command length in clocks
    // Wire levels from every party's enable
    assign i_slot_data_bus = o_slot_data_oe ? o_slot_data_bus : card_data;
    assign i_slot_address_bus = (o_slot_address_bus & o_slot_address_oe) | (20'hA5A5A & ~o_slot_address_oe);
    assign i_latched_upper_address = o_latched_upper_oe ? o_latched_upper_address : 7'h55;
    assign i_byte_high_enable_n = o_byte_high_enable_oe ? o_byte_high_enable_n : 1'b1;
    assign i_strobes_n = o_strobes_oe ? o_strobes_n : 4'hF;
    assign i_dma_acknowledge_n = (o_dma_acknowledge_n & o_dma_acknowledge_oe) | (STRAP & ~o_dma_acknowledge_oe);
    assign i_wide_io_select_n = i_wide_memory_select_n;
    leb_card leb_card_i (.i_ref_clk(i_ref_clk), .i_strobes_n(i_strobes_n), .i_rd_word(rd_word),
        .i_wait(card_wait), .o_card_data(card_data), .o_card_ready(i_channel_ready),
        .o_card_wide_n(i_wide_memory_select_n));
    leb_host #(.RST_HOLD(16'h0004)) leb_host_i (.*);
    always #12.5 i_ref_clk = ~i_ref_clk;
    // Catch the terminal count pulse
    always @(posedge i_ref_clk) if (o_transfer_count_done === 1'b1) tc_seen <= 1'b1;
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_v({23'h000000, got}, {23'h000000, exp});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Strobe pattern each command should show
    function automatic logic [3:0] pat(input logic [2:0] c);
        case (c)
            3'h1, 3'h6: pat = 4'hB;
            3'h2, 3'h4: pat = 4'hD;
            3'h3: pat = 4'hE;
            default: pat = 4'h7;
        endcase
    endfunction
    // One request; pins judged while its strobe is low, width kept in wid
    task automatic bus(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d,
            input logic [2:0] ch);
        int n;
        logic ale;
        n = 0;
        ale = 1'b0;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_cmd <= c;
        i_req_addr <= a;
        i_req_wdata <= d;
        i_req_dma_ch <= ch;
        i_req_last <= 1'b1;
        tc_seen <= 1'b0;
        do @(posedge i_ref_clk); while (o_req_ready !== 1'b1 && ++n < 800);
        chk_b(n < 800, 1'b1);
        i_req_valid <= 1'b0;
        n = 0;
        while (!(o_strobes_oe === 1'b1 && o_strobes_n !== 4'hF) && n++ < 200) begin
            ale |= o_address_latch_enable;
            tk(1);
        end
        chk_b(n <= 200, 1'b1);
        chk_b(ale, 1'b1);
        chk_v(o_strobes_n, pat(c));
        chk_v(o_slot_address_bus, a[19:0]);
        chk_v(o_latched_upper_address, a[23:17]);
        chk_b(o_byte_high_enable_n, 1'b0);
        chk_b(o_address_enable_out, c >= 3'h5);
        chk_b(o_refresh_n, c != 3'h5);
        if (c >= 3'h6) chk_v({8'h00, ~o_dma_acknowledge_n}, 16'h0001 << ch);
        if (c == 3'h1 || c == 3'h3) chk_v(o_slot_data_bus, d);
        if (c < 3'h2) chk_b(c[0] ? o_low_meg_write_strobe_n : o_low_meg_read_strobe_n, a >= 24'h100000);
        wid = 0;
        while (o_strobes_n !== 4'hF && wid < 800) begin
            tk(1);
            wid++;
        end
        chk_b(wid < 800, 1'b1);
        n = 0;
        while (o_busy !== 1'b0 && n++ < 200) tk(1);
        chk_b(n <= 200, 1'b1);
        tk(3);
        if (c >= 3'h6) chk_b(tc_seen, 1'b1);
        chk_b(o_cycle_wide, 1'b1);
    endtask
    // Take one word from the read stream
    task automatic pop(output logic [15:0] w);
        int n;
        n = 0;
        i_rd_ready <= 1'b1;
        do @(posedge i_ref_clk); while (o_rd_valid !== 1'b1 && ++n < 200);
        chk_b(n < 200, 1'b1);
        w = o_rd_data;
        i_rd_ready <= 1'b0;
        tk(1);
    endtask
    task automatic t_power();
        int n;
        n = 0;
        tk(10);
        chk_b(o_slot_reset_out, 1'b1);
        i_power_good <= 1'b1;
        while (o_req_ready !== 1'b1 && n++ < 2000) tk(1);
        chk_b(o_slot_reset_out, 1'b0);
        chk_v(o_strap_q, STRAP);
    endtask
    task automatic t_pins();
        logic b;
        b = o_bus_clock_out;
        tk(`LEB_CLK_DIV);
        chk_b(o_bus_clock_out, !b);
        i_irq <= 16'hFFFF;
        i_dma_request_in <= 8'hFF;
        i_channel_error_in_n <= 1'b0;
        tk(6);
        chk_v(o_irq_level, 16'hDEF8);
        chk_v(o_dma_pending, 8'hEF);
        chk_b(o_channel_error, 1'b1);
        i_irq <= 16'h0000;
        i_dma_request_in <= 8'h00;
        i_channel_error_in_n <= 1'b1;
        tk(6);
        chk_v({o_irq_level, o_dma_pending}, 24'h000000);
        chk_b(o_channel_error, 1'b0);
    endtask
    // Every command code, then reads and writes above one meg
    task automatic t_cmds();
        logic [15:0] w;
        rd_word <= 16'hC35A;
        for (int c = 0; c < 8; c++) bus(c[2:0], 24'h0ABCDE, 16'h1234 + c[15:0], 3'h5);
        bus(3'h0, 24'h1F0000, 16'h0000, 3'h0);
        bus(3'h1, 24'h1F0000, 16'hA55A, 3'h0);
        for (int k = 0; k < 5; k++) begin
            pop(w);
            if (k != 3) chk_v(w, 16'hC35A);
        end
    endtask
    // Fill the read buffer with the reader stalled, then drain in order
    task automatic t_fifo();
        logic [15:0] w;
        for (int k = 0; k < 16; k++) begin
            rd_word <= 16'h0100 + k[15:0];
            bus(3'h0, 24'h000400 + k[23:0], 16'h0000, 3'h0);
        end
        for (int k = 0; k < 16; k++) begin
            pop(w);
            chk_v(w, 16'h0100 + k[15:0]);
        end
    endtask
    // Slow card, plain card, zero-wait card
    task automatic t_timing();
        card_wait <= 8'h3C;
        bus(3'h3, 24'h000300, 16'h00FF, 3'h0);
        chk_b(wid >= 60, 1'b1);
        card_wait <= 8'h00;
        bus(3'h3, 24'h000300, 16'h00FF, 3'h0);
        chk_b(wid >= WAIT_CLK - 4, 1'b1);
        i_zero_wait_in_n <= 1'b0;
        bus(3'h3, 24'h000300, 16'h00FF, 3'h0);
        chk_b(wid < WAIT_CLK - 4, 1'b1);
        i_zero_wait_in_n <= 1'b1;
    endtask
    // Hold, then a card master, then back to the host
    task automatic t_master();
        i_hold_ack <= 1'b1;
        tk(5);
        chk_v(o_slot_address_oe[16:0], 24'h000000);
        i_hold_ack <= 1'b0;
        i_master_cycle <= 1'b1;
        tk(5);
        chk_v({o_strobes_oe, o_latched_upper_oe, o_byte_high_enable_oe}, 24'h000000);
        i_master_cycle <= 1'b0;
        tk(5);
        chk_v({o_strobes_oe, o_latched_upper_oe}, 24'h000003);
    endtask
    initial begin
        tk(20);
        i_rst <= 1'b0;
        t_power();
        t_pins();
        t_cmds();
        t_fifo();
        t_timing();
        t_master();
        wrap_up();
    end
    // Watchdog well past the expected run
    initial begin
        #2000000;
        miscompares++;
        wrap_up();
    end
endmodule // leb_host_test
